/* File: hdl/afd_pkg.sv */
// Package for the firmware download command block: task-file offsets, opcodes,
// bit positions, checksum constants and the carrier structs.
// Assumes a single 200 MHz clock domain and an 8-bit task-file register port.
package afd_pkg;

	// Task-file register offsets on the plain register port
	localparam logic [3:0] OFS_PARAM_ERR  = 4'h1; // cmd_parameter (W) / error_flags (R)
	localparam logic [3:0] OFS_SC_LOW     = 4'h2;
	localparam logic [3:0] OFS_SC_HIGH    = 4'h3;
	localparam logic [3:0] OFS_OFF_LOW    = 4'h4;
	localparam logic [3:0] OFS_OFF_HIGH   = 4'h5;
	localparam logic [3:0] OFS_DRIVE_SEL  = 4'h6;
	localparam logic [3:0] OFS_OPC_STAT   = 4'h7; // opcode (W) / drive_status (R)

	// Opcodes and download subcommands
	localparam logic [7:0] OPC_FW_DOWNLOAD = 8'h92;
	localparam logic [7:0] OPC_DIAGNOSTIC  = 8'h90;
	localparam logic [7:0] SUB_SEGMENTED   = 8'h03;
	localparam logic [7:0] SUB_SINGLE      = 8'h07;

	// Error and status bit positions
	localparam int ERR_UNC_BIT = 6;
	localparam int ERR_ABT_BIT = 2;
	localparam int ST_BSY_BIT  = 7;
	localparam int ST_RDY_BIT  = 6;
	localparam int ST_DSC_BIT  = 4;
	localparam int ST_DRQ_BIT  = 3;
	localparam int ST_ERR_BIT  = 0;

	// Reset values
	localparam logic [7:0]  TF_RESET     = 8'h00;
	localparam logic [15:0] EXPECT_RESET = 16'h0000;

	// Transfer geometry: 512-byte sectors carried as 16-bit data words
	localparam logic [24:0] WORDS_PER_SECTOR = 25'h0000100;

	// Configuration structure integrity word
	localparam logic [7:0] CFG_SIGNATURE = 8'hA5;
	localparam logic [7:0] CFG_LAST_WORD = 8'hFE; // Word 254, the last summed whole word

	// Configuration-overlay rejection reason codes
	localparam logic [7:0] DCO_FROZEN      = 8'h01;
	localparam logic [7:0] DCO_SEC_LOCKED  = 8'h02;
	localparam logic [7:0] DCO_MODIFIED    = 8'h03;
	localparam logic [7:0] DCO_DISABLE_EN  = 8'h04;
	localparam logic [7:0] DCO_MAX_LOCKED  = 8'h05;
	localparam logic [7:0] DCO_PROTECTED   = 8'h06;
	localparam logic [7:0] DCO_UNSUPPORTED = 8'h07;
	localparam logic [7:0] DCO_BAD_SUBCMD  = 8'h08;
	localparam logic [7:0] DCO_OTHER       = 8'hFF;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} afd_req_s;

	// Configuration-overlay rejection report
	typedef struct packed {
		logic       valid;
		logic [7:0] word_idx;
		logic [7:0] mask_hi;
		logic [7:0] mask_lo;
		logic [7:0] reason;
	} afd_dco_s;

endpackage

/* File: hdl/afd_core.sv */
// Firmware download command interpreter with task-file registers, overlay
// rejection reporting, configuration checksum and diagnostic result capture.
// Assumes the host port, data stream and firmware store are synchronous to ref_clk_i.
//
// Decided for this implementation: the strobed register port and the register addresses.
module afd_core
	import afd_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire afd_req_s    req_i,
	output logic [7:0]       rdata_o,
	input  wire logic        srst_i,
	input  wire logic        sec_locked_i,
	input  wire logic        spinup_dis_i,
	input  wire logic        dat_valid_i,
	input  wire logic [15:0] dat_i,
	output logic             dat_ready_o,
	output logic             fw_wr_o,
	output logic [24:0]      fw_addr_o,
	output logic [15:0]      fw_data_o,
	input  wire logic        fw_last_i,
	output logic             fw_save_o,
	output logic             fw_discard_o,
	input  wire logic        fw_done_i,
	input  wire logic        fw_reload_req_i,
	input  wire logic        fw_reload_fail_i,
	output logic             spin_down_o,
	output logic             diag_start_o,
	input  wire logic        diag_done_i,
	input  wire logic [7:0]  diag_code_i,
	output logic             ext_cmd_o,
	output logic [7:0]       ext_opcode_o,
	input  wire afd_dco_s    dco_i,
	input  wire logic        cfg_valid_i,
	input  wire logic [15:0] cfg_word_i,
	output logic             integ_valid_o,
	output logic [15:0]      integ_word_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_SAVE, ST_DIAG} afd_state_e;

	// Register address decode, shared by reads and writes
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	afd_state_e  state_q, state_d;
	logic [7:0]  param_q, sc_lo_q, sc_hi_q, off_lo_q, off_hi_q, dsel_q, err_q, rdata_q;
	logic        errst_q, seg_mode_q, ready_q, wr_q, save_q, disc_q, spin_q;
	logic        diag_q, ext_q, iv_q;
	logic [7:0]  ext_opc_q, sum_q, widx_q;
	logic [15:0] expect_q, fw_data_q, integ_q, cur_len_q;
	logic [24:0] waddr_q, wleft_q;

	// Command decode on an opcode write while not busy
	// An opcode written while busy is dropped without an error, since the host polls BSY first
	wire         cmd_wr      = req_i.wr && hit(req_i.addr, OFS_OPC_STAT) && state_q == ST_IDLE;
	wire         is_dl       = cmd_wr && req_i.wdata == OPC_FW_DOWNLOAD;
	wire         is_diag     = cmd_wr && req_i.wdata == OPC_DIAGNOSTIC;
	wire         is_other    = cmd_wr && !is_dl && !is_diag;
	wire         sub_seg     = param_q == SUB_SEGMENTED;
	wire         sub_ok      = sub_seg || param_q == SUB_SINGLE;
	wire [15:0]  len_w       = {sc_hi_q, sc_lo_q};
	wire [15:0]  off_w       = {off_hi_q, off_lo_q};
	wire         dl_bad_sub  = is_dl && (!sub_ok || sec_locked_i);
	wire         dl_bad_seq  = is_dl && !dl_bad_sub && sub_seg && off_w != expect_q;
	wire         dl_good     = is_dl && !dl_bad_sub && !dl_bad_seq;
	wire         dl_start    = dl_good && len_w != 16'h0000;
	wire         partial     = expect_q != EXPECT_RESET;
	wire         word_take   = state_q == ST_XFER && ready_q && dat_valid_i;
	wire         last_word   = word_take && wleft_q == 25'h0000001;
	wire         final_seg   = !seg_mode_q || fw_last_i;
	wire         save_end    = state_q == ST_SAVE && fw_done_i;
	wire         reload_bad  = save_end && fw_reload_req_i && fw_reload_fail_i;
	wire         reload_ok   = save_end && fw_reload_req_i && !fw_reload_fail_i;
	wire         diag_end    = state_q == ST_DIAG && diag_done_i;
	wire         discard_now = (srst_i && (partial || state_q == ST_XFER))
	                         || (is_other && partial)
	                         || dl_bad_seq
	                         || (dl_good && !sub_seg && partial);
	wire [7:0]   sum_w       = 8'(sum_q + cfg_word_i[7:0] + cfg_word_i[15:8]);
	wire [7:0]   chk_w       = 8'(8'h00 - 8'(sum_w + CFG_SIGNATURE));

	// Next state; a software reset overrides any command in progress
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (dl_start)
					state_d = ST_XFER;
				else if (is_diag)
					state_d = ST_DIAG;
			end
			ST_XFER: begin
				if (last_word)
					state_d = final_seg ? ST_SAVE : ST_IDLE;
			end
			ST_SAVE: begin
				if (fw_done_i)
					state_d = ST_IDLE;
			end
			ST_DIAG: begin
				if (diag_done_i)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		if (srst_i)
			state_d = ST_IDLE;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Host-writable task-file registers; a rejection report overrides a host write
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			param_q  <= TF_RESET;
			sc_lo_q  <= TF_RESET;
			sc_hi_q  <= TF_RESET;
			off_lo_q <= TF_RESET;
			off_hi_q <= TF_RESET;
			dsel_q   <= TF_RESET;
		end else if (dco_i.valid) begin
			sc_lo_q  <= dco_i.reason;
			sc_hi_q  <= dco_i.mask_lo;
			off_lo_q <= dco_i.mask_hi;
			off_hi_q <= dco_i.word_idx;
		end else if (req_i.wr) begin
			if (hit(req_i.addr, OFS_PARAM_ERR))
				param_q <= req_i.wdata;
			if (hit(req_i.addr, OFS_SC_LOW))
				sc_lo_q <= req_i.wdata;
			if (hit(req_i.addr, OFS_SC_HIGH))
				sc_hi_q <= req_i.wdata;
			if (hit(req_i.addr, OFS_OFF_LOW))
				off_lo_q <= req_i.wdata;
			if (hit(req_i.addr, OFS_OFF_HIGH))
				off_hi_q <= req_i.wdata;
			if (hit(req_i.addr, OFS_DRIVE_SEL))
				dsel_q <= req_i.wdata;
		end
	end

	// Error register and status error bit; each new command clears old errors first
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			err_q   <= TF_RESET;
			errst_q <= 1'b0;
		end else if (srst_i) begin
			err_q   <= TF_RESET;
			errst_q <= 1'b0;
		end else if (dl_bad_sub || dl_bad_seq || dco_i.valid) begin
			err_q   <= 8'h01 << ERR_ABT_BIT;
			errst_q <= 1'b1;
		end else if (reload_bad) begin
			err_q   <= 8'h01 << ERR_UNC_BIT;
			errst_q <= 1'b1;
		end else if (diag_end) begin
			err_q   <= diag_code_i;
			errst_q <= 1'b0;
		end else if (cmd_wr) begin
			err_q   <= TF_RESET;
			errst_q <= 1'b0;
		end
	end

	// Segment sequence tracking; cleared whenever partial microcode is abandoned
	// A bad subcommand abort leaves the sequence alone, so a corrected retry can continue
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			expect_q   <= EXPECT_RESET;
			seg_mode_q <= 1'b0;
			cur_len_q  <= 16'h0000;
		end else if (discard_now || save_end) begin
			expect_q   <= EXPECT_RESET;
			seg_mode_q <= 1'b0;
		end else if (dl_start) begin
			seg_mode_q <= sub_seg;
			cur_len_q  <= len_w;
		end else if (last_word && seg_mode_q && !fw_last_i) begin
			expect_q   <= 16'(expect_q + cur_len_q);
		end
	end

	// Word transfer into the firmware store; ready drops with the last word
	// The address runs one word ahead of the data, so the store uses fw_addr_o minus one
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ready_q   <= 1'b0;
			wr_q      <= 1'b0;
			waddr_q   <= 25'h0000000;
			wleft_q   <= 25'h0000000;
			fw_data_q <= 16'h0000;
		end else begin
			ready_q <= state_d == ST_XFER;
			wr_q    <= word_take && !srst_i;
			if (dl_start) begin
				waddr_q <= 25'(sub_seg ? off_w : 16'h0000) * WORDS_PER_SECTOR;
				wleft_q <= 25'(len_w) * WORDS_PER_SECTOR;
			end else if (word_take) begin
				waddr_q   <= 25'(waddr_q + 25'h0000001);
				wleft_q   <= 25'(wleft_q - 25'h0000001);
				fw_data_q <= dat_i;
			end
			if (dl_start || word_take)
				fw_data_q <= dat_i;
		end
	end

	// One-cycle command pulses toward the firmware store, spindle and diagnostics
	// A software reset in the same cycle swallows every pulse except the discard
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			save_q    <= 1'b0;
			disc_q    <= 1'b0;
			spin_q    <= 1'b0;
			diag_q    <= 1'b0;
			ext_q     <= 1'b0;
			ext_opc_q <= TF_RESET;
		end else begin
			save_q <= last_word && final_seg && !srst_i;
			disc_q <= discard_now;
			spin_q <= reload_ok && spinup_dis_i && !srst_i;
			diag_q <= is_diag && !srst_i;
			ext_q  <= is_other && !srst_i;
			if (is_other)
				ext_opc_q <= req_i.wdata;
		end
	end

	// Integrity word of the configuration structure, one byte sum per word
	// The word counter only rewinds after word 254 or on reset: feed whole structures
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sum_q   <= 8'h00;
			widx_q  <= 8'h00;
			iv_q    <= 1'b0;
			integ_q <= 16'h0000;
		end else begin
			iv_q <= cfg_valid_i && widx_q == CFG_LAST_WORD;
			if (cfg_valid_i) begin
				if (widx_q == CFG_LAST_WORD) begin
					integ_q <= {chk_w, CFG_SIGNATURE};
					sum_q   <= 8'h00;
					widx_q  <= 8'h00;
				end else begin
					sum_q  <= sum_w;
					widx_q <= 8'(widx_q + 8'h01);
				end
			end
		end
	end

	// Read data stands only in the cycle after the read strobe
	wire [7:0] status_w = (8'(state_q != ST_IDLE) << ST_BSY_BIT)
	                    | (8'h01 << ST_RDY_BIT) | (8'h01 << ST_DSC_BIT)
	                    | (8'(state_q == ST_XFER) << ST_DRQ_BIT)
	                    | (8'(errst_q) << ST_ERR_BIT);
	wire [7:0] rmux_w = hit(req_i.addr, OFS_PARAM_ERR) ? err_q
	                  : hit(req_i.addr, OFS_SC_LOW)    ? sc_lo_q
	                  : hit(req_i.addr, OFS_SC_HIGH)   ? sc_hi_q
	                  : hit(req_i.addr, OFS_OFF_LOW)   ? off_lo_q
	                  : hit(req_i.addr, OFS_OFF_HIGH)  ? off_hi_q
	                  : hit(req_i.addr, OFS_DRIVE_SEL) ? dsel_q
	                  : hit(req_i.addr, OFS_OPC_STAT)  ? status_w
	                  : 8'h00;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata_q <= 8'h00;
		else
			rdata_q <= req_i.rd ? rmux_w : 8'h00;
	end

	// Every output is a flop, so nothing combinational reaches the pins
	assign rdata_o       = rdata_q;
	assign dat_ready_o   = ready_q;
	assign fw_wr_o       = wr_q;
	assign fw_addr_o     = waddr_q;
	assign fw_data_o     = fw_data_q;
	assign fw_save_o     = save_q;
	assign fw_discard_o  = disc_q;
	assign spin_down_o   = spin_q;
	assign diag_start_o  = diag_q;
	assign ext_cmd_o     = ext_q;
	assign ext_opcode_o  = ext_opc_q;
	assign integ_valid_o = iv_q;
	assign integ_word_o  = integ_q;

	// Checks on the block's own registers, state and outputs
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	a_integ_signature: assert property (iv_q |-> integ_q[7:0] == CFG_SIGNATURE)
		else $error("integrity low byte is not the signature");
	a_overlay_report: assert property (dco_i.valid |=> off_hi_q == $past(dco_i.word_idx)
		&& sc_hi_q == $past(dco_i.mask_lo)) else $error("overlay report not loaded");
	a_overlay_reason: assert property (dco_i.valid |=> sc_lo_q == $past(dco_i.reason))
		else $error("overlay reason not loaded");
	a_bad_sub_abort: assert property (dl_bad_sub && !srst_i && !dco_i.valid |=>
		err_q == 8'h04 && errst_q && state_q == ST_IDLE) else $error("bad subcommand not aborted");
	a_zero_len_idle: assert property (dl_good && len_w == 16'h0000 && !srst_i |=>
		state_q == ST_IDLE ##1 !ready_q) else $error("zero length moved data");
	a_unc_only_reload: assert property ($rose(err_q[ERR_UNC_BIT]) |->
		$past(fw_reload_req_i) && $past(fw_reload_fail_i)) else $error("UNC without reload");
	a_seq_discard: assert property (dl_bad_seq && !srst_i |=> fw_discard_o
		&& expect_q == EXPECT_RESET) else $error("out of sequence segment kept");
	a_save_after_last: assert property (last_word && final_seg && !srst_i |=>
		fw_save_o && state_q == ST_SAVE) else $error("final segment not saved");
	a_other_discard: assert property (is_other && partial && !srst_i |=>
		fw_discard_o && ext_cmd_o) else $error("partial microcode kept");
	a_srst_drop: assert property (srst_i && partial |=> expect_q == EXPECT_RESET
		&& state_q == ST_IDLE) else $error("reset did not drop segments");
	a_diag_code: assert property (diag_end && !srst_i && !dco_i.valid |=>
		err_q == $past(diag_code_i)) else $error("diagnostic code not stored");
	a_spin_down: assert property (reload_ok && spinup_dis_i && !srst_i |=> spin_down_o)
		else $error("no spin down after reload");
	a_xfer_ends: assert property (last_word && !final_seg && !srst_i |=>
		state_q == ST_IDLE ##1 !ready_q) else $error("transfer did not end");

	// Store, address and pulse checks formulated from the rules, not from the flops
	a_store_write: assert property (word_take && !srst_i |=> fw_wr_o
		&& fw_data_o == $past(dat_i)) else $error("accepted word not written");
	a_seg_address: assert property (dl_start && sub_seg |=>
		fw_addr_o == {1'b0, $past(off_w), 8'h00}) else $error("segment start address wrong");
	a_single_base: assert property (dl_start && !sub_seg |=>
		fw_addr_o == 25'h0000000) else $error("single download not at image start");
	a_diag_start: assert property (is_diag && !srst_i |=> diag_start_o
		&& state_q == ST_DIAG) else $error("diagnostic not started");
	a_other_pulse: assert property (is_other && !srst_i |=> ext_cmd_o
		&& ext_opcode_o == $past(req_i.wdata)) else $error("other opcode not passed on");
	a_single_discard: assert property (dl_good && !sub_seg && partial |=>
		fw_discard_o) else $error("single download kept partial segments");
	a_seq_advance: assert property (last_word && seg_mode_q && !fw_last_i && !srst_i |=>
		expect_q == 16'($past(expect_q) + $past(cur_len_q))) else $error("offset not advanced");
	a_unc_set: assert property (reload_bad && !srst_i && !dco_i.valid |=>
		err_q[ERR_UNC_BIT] && errst_q) else $error("failed reload not reported");

	c_segment_advance: cover property (last_word && seg_mode_q && !fw_last_i);
	c_full_save: cover property (save_end && fw_reload_req_i);
	c_diag_run: cover property (diag_end);
	c_integ_out: cover property (iv_q);
	c_seq_reject: cover property (dl_bad_seq);

endmodule // afd_core

/* File: test/afd_host_model.sv */
// Far-side model: host data source and image store for the download block.
// Assumes it shares ref_clk_i with the block; reload flags come from the bench.
module afd_host_model
	import afd_pkg::*;
(
	input  wire logic   ref_clk_i,
	input  wire logic   rstn_i,
	input  wire logic   dat_ready_i,
	input  wire logic   fw_save_i,
	output logic        dat_valid_o,
	output logic [15:0] dat_o,
	output logic        fw_done_o
);
	logic [15:0] word_q;
	logic [3:0]  pace_q;
	logic [2:0]  save_q;
	// Pace only moves while the block is ready, so a raised word is held until taken
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_q <= 16'h0000;
			pace_q <= 4'h0;
			save_q <= 3'h0;
		end else begin
			pace_q <= pace_q + {3'h0, dat_ready_i};
			save_q <= {save_q[1:0], fw_save_i}; // Save answered after three cycles
			if (dat_valid_o && dat_ready_i) begin
				word_q <= word_q + 16'h0001; // Keeps sending until ready falls
			end
		end
	end
	// One stall slot in sixteen; stale lines show the inverse so they never look fresh
	assign dat_valid_o = (pace_q != 4'hF);
	assign dat_o       = dat_valid_o ? word_q : ~word_q;
	assign fw_done_o   = save_q[2];
endmodule // afd_host_model

/* File: test/tb_ata_firmware_download_commands.sv */
// Self-checking bench for the firmware download block: register port, overlay
// reports, configuration words; the host model feeds data and answers saves.
module tb_ata_firmware_download_commands
	import afd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rstn, srst, sec_locked, spinup_dis, fw_last, rl_req, rl_fail;
	logic        dat_valid, dat_ready, fw_wr, fw_save, fw_discard, fw_done, spin_down;
	logic        diag_start, diag_done, ext_cmd, cfg_valid, integ_valid;
	logic [7:0]  rdata, ext_opcode, diag_code, v;
	logic [15:0] dat, fw_data, cfg_word, integ_word, exp_word;
	logic [24:0] fw_addr, exp_addr;
	afd_req_s    req;
	afd_dco_s    dco;
	int          mismatches, checks, n_wr, n_save, n_disc, n_spin, n_ext, n_integ;

	afd_core dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .req_i(req), .rdata_o(rdata),
		.srst_i(srst), .sec_locked_i(sec_locked), .spinup_dis_i(spinup_dis),
		.dat_valid_i(dat_valid), .dat_i(dat), .dat_ready_o(dat_ready), .fw_wr_o(fw_wr),
		.fw_addr_o(fw_addr), .fw_data_o(fw_data), .fw_last_i(fw_last), .fw_save_o(fw_save),
		.fw_discard_o(fw_discard), .fw_done_i(fw_done), .fw_reload_req_i(rl_req),
		.fw_reload_fail_i(rl_fail), .spin_down_o(spin_down), .diag_start_o(diag_start),
		.diag_done_i(diag_done), .diag_code_i(diag_code), .ext_cmd_o(ext_cmd),
		.ext_opcode_o(ext_opcode), .dco_i(dco), .cfg_valid_i(cfg_valid),
		.cfg_word_i(cfg_word), .integ_valid_o(integ_valid), .integ_word_o(integ_word));
	afd_host_model host (.ref_clk_i(ref_clk), .rstn_i(rstn), .dat_ready_i(dat_ready),
		.fw_save_i(fw_save), .dat_valid_o(dat_valid), .dat_o(dat), .fw_done_o(fw_done));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Store monitor: each write carries the next host word at the next address
	always @(posedge ref_clk) begin
		diag_done <= diag_start;
		if (fw_wr === 1'b1) begin
			chk("fw_data", 25'(exp_word), 25'(fw_data));
			chk("fw_addr", exp_addr, fw_addr - 25'h0000001);
			exp_word <= exp_word + 16'h0001;
			exp_addr <= exp_addr + 25'h0000001;
		end
		n_wr <= n_wr + int'(fw_wr === 1'b1);
		n_save <= n_save + int'(fw_save === 1'b1);
		n_disc <= n_disc + int'(fw_discard === 1'b1);
		n_spin <= n_spin + int'(spin_down === 1'b1);
		n_ext <= n_ext + int'(ext_cmd === 1'b1);
		n_integ <= n_integ + int'(integ_valid === 1'b1);
	end

	task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle strobes with a gap, so no signal is assigned twice in a time step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req <= '0;
		#1 d = rdata;
	endtask
	task automatic idle(output logic [7:0] s);
		for (int i = 0; i < 400; i++) begin
			rd(OFS_OPC_STAT, s);
			if (s[ST_BSY_BIT] === 1'b0) break;
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	// Parameters first, opcode last; counters cleared off the edge
	task automatic cmd(input logic [7:0] sub, input logic [15:0] len, input logic [15:0] off);
		#1;
		exp_addr = {1'b0, off, 8'h00};
		{n_wr, n_save, n_disc, n_spin, n_ext} = '0;
		wr(OFS_PARAM_ERR, sub);
		wr(OFS_SC_LOW, len[7:0]);
		wr(OFS_SC_HIGH, len[15:8]);
		wr(OFS_OFF_LOW, off[7:0]);
		wr(OFS_OFF_HIGH, off[15:8]);
		wr(OFS_OPC_STAT, OPC_FW_DOWNLOAD);
	endtask

	task automatic t_regs();
		for (int a = 2; a < 7; a++) begin
			wr(4'(a), 8'(a * 17));
			rd(4'(a), v);
			chk("tf_reg", 25'(8'(a * 17)), v);
		end
		rd(4'h8, v);
		chk("unmapped", 8'h00, v);
		rd(OFS_PARAM_ERR, v);
		chk("error", 8'h00, v);
		$display("t_regs done");
	endtask
	task automatic t_zero();
		cmd(SUB_SINGLE, 16'h0000, 16'h0000);
		repeat (20) @(posedge ref_clk);
		rd(OFS_OPC_STAT, v);
		chk("status", 8'h50, v);
		chk("words", 0, n_wr);
		$display("t_zero done");
	endtask
	task automatic t_reload(input logic r, input logic f, input logic [7:0] e, input int sp);
		rl_req <= r;
		rl_fail <= f;
		spinup_dis <= 1'b1;
		cmd(SUB_SINGLE, 16'h0001, 16'h0000);
		rd(OFS_OPC_STAT, v);
		chk("busy", 8'hD8, v);
		idle(v);
		chk("status", (e == 8'h00) ? 8'h50 : 8'h51, v);
		chk("words", 256, n_wr);
		chk("save", 1, n_save);
		chk("spin", sp, n_spin);
		rd(OFS_PARAM_ERR, v);
		chk("error", e, v);
		$display("t_reload done");
	endtask
	task automatic t_badsub();
		logic [7:0] subs [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'hFF,
			8'h07, 8'h03};
		for (int i = 0; i < 10; i++) begin
			sec_locked <= (i > 7);
			cmd(subs[i], 16'h0001, 16'h0000);
			rd(OFS_PARAM_ERR, v);
			chk("error", 8'h04, v);
			rd(OFS_OPC_STAT, v);
			chk("status", 8'h51, v);
		end
		sec_locked <= 1'b0;
		$display("t_badsub done");
	endtask
	task automatic t_srst();
		cmd(SUB_SEGMENTED, 16'h0100, 16'h0000);
		repeat (600) @(posedge ref_clk);
		rd(OFS_OPC_STAT, v);
		chk("busy", 8'hD8, v);
		chk("long", 1, n_wr > 300);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("discard", 1, n_disc);
		// A word handed over in the reset cycle is dropped, so follow the source again
		exp_word = host.word_q;
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0001);
		rd(OFS_PARAM_ERR, v);
		chk("error", 8'h04, v);
		$display("t_srst done");
	endtask
	task automatic t_seq();
		fw_last <= 1'b0;
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0000);
		idle(v);
		chk("save", 0, n_save);
		fw_last <= 1'b1;
		cmd(SUB_SEGMENTED, 16'h0002, 16'h0001);
		idle(v);
		chk("words", 512, n_wr);
		chk("save", 1, n_save);
		fw_last <= 1'b0;
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0000);
		idle(v);
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0005);
		rd(OFS_PARAM_ERR, v);
		chk("error", 8'h04, v);
		chk("discard", 1, n_disc);
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0001);
		rd(OFS_PARAM_ERR, v);
		chk("error", 8'h04, v);
		$display("t_seq done");
	endtask
	task automatic t_other();
		cmd(SUB_SEGMENTED, 16'h0001, 16'h0000);
		idle(v);
		wr(OFS_OPC_STAT, 8'hE7);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("ext", 1, n_ext);
		chk("ext_op", 8'hE7, ext_opcode);
		chk("discard", 1, n_disc);
		wr(OFS_OPC_STAT, OPC_DIAGNOSTIC);
		idle(v);
		chk("status", 8'h50, v);
		rd(OFS_PARAM_ERR, v);
		chk("diag", 8'h3C, v);
		$display("t_other done");
	endtask
	task automatic t_dco();
		logic [7:0] codes [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
			8'hFF};
		for (int i = 0; i < 9; i++) begin
			@(posedge ref_clk);
			dco <= '{1'b1, 8'(i + 16), 8'hC0 ^ 8'(i), 8'h0F ^ 8'(i), codes[i]};
			@(posedge ref_clk);
			dco <= '0;
			rd(OFS_SC_LOW, v);
			chk("reason", codes[i], v);
			rd(OFS_SC_HIGH, v);
			chk("mask_lo", 8'h0F ^ 8'(i), v);
			rd(OFS_OFF_LOW, v);
			chk("mask_hi", 8'hC0 ^ 8'(i), v);
			rd(OFS_OFF_HIGH, v);
			chk("word_idx", 8'(i + 16), v);
		end
		$display("t_dco done");
	endtask
	task automatic t_cfg();
		logic [7:0]  s;
		logic [15:0] w;
		s = 8'hA5;
		n_integ = 0;
		for (int i = 0; i < 255; i++) begin
			w = {8'(i), 8'(i) ^ 8'h5A};
			s = s + w[15:8] + w[7:0];
			@(posedge ref_clk);
			cfg_valid <= 1'b1;
			cfg_word <= w;
		end
		@(posedge ref_clk);
		cfg_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("integ", 1, n_integ);
		chk("signature", 8'hA5, integ_word[7:0]);
		chk("checksum", 8'(8'h00 - s), integ_word[15:8]);
		chk("sum_zero", 8'h00, 8'(s + integ_word[15:8]));
		$display("t_cfg done");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Whole run is near 3600 cycles; the limit leaves ample margin
	initial begin
		#400us;
		mismatches++;
		stop_test();
	end
	initial begin
		{rstn, srst, sec_locked, spinup_dis, fw_last, rl_req, rl_fail, cfg_valid} = '0;
		{req, dco, cfg_word, exp_word, exp_addr, diag_done} = '0;
		{mismatches, checks, n_wr, n_save, n_disc, n_spin, n_ext, n_integ} = '0;
		diag_code = 8'h3C;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_zero();
		t_reload(1'b1, 1'b0, 8'h00, 1);
		t_reload(1'b1, 1'b1, 8'h40, 0);
		t_reload(1'b0, 1'b1, 8'h00, 0);
		t_badsub();
		t_srst();
		t_seq();
		t_other();
		t_dco();
		t_cfg();
		stop_test();
	end
endmodule // tb_ata_firmware_download_commands
